// >>> dv/tba_cap.sv
// capture side model: sample clock source and word latch
// assumes phase lengths of 3 to 7 cycles from the bench
`timescale 1ns/10ps
`default_nettype none
module tba_cap (
  input  wire logic        clk_sys,
  input  wire logic        run,
  input  wire logic [3:0]  hi,
  input  wire logic [3:0]  lo,
  input  wire logic [10:0] pins,
  output logic             sample_clk,
  output logic             stb,
  output var tba_pkg::tba_word_s cap
);
  import tba_pkg::*;
  int n = 0;
  int d = 0;
  initial begin
    sample_clk = 1'h0;
    stb = 1'h0;
    cap = '0;
  end
  // clock toggles only while run is high, phases of hi and lo cycles; latch after settling
  always @(negedge clk_sys) begin
    stb <= 1'h0;
    n <= n + 1;
    if (d > 0) d <= d - 1;
    if (run && n + 1 >= int'(sample_clk ? hi : lo)) begin
      sample_clk <= !sample_clk;
      n <= 0;
      if (sample_clk) d <= 7;
    end
    if (d == 1) begin
      stb <= 1'h1;
      cap <= pins;
    end
  end
endmodule // tba_cap
`default_nettype wire

// >>> dv/tba_monitor.sv
// pin checker for the converter output side
// assumes binding into tba_top
`timescale 1ns/10ps
`default_nettype none
module tba_monitor (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       sample_clk,
  input wire logic       over_range,
  input wire logic       result_bit_top,
  input wire logic [3:0] result_bits_upper_mid,
  input wire logic [3:0] result_bits_lower_mid,
  input wire logic       result_bit_bottom
);
  wire [10:0] w = {over_range, result_bit_top, result_bits_upper_mid,
                   result_bits_lower_mid, result_bit_bottom};
  logic       sc_r;
  logic [3:0] sf_r;
  logic [1:0] nf_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // cycles since a pin fall, falls since reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sc_r <= 1'h0;
      sf_r <= 4'hf;
      nf_r <= 2'h0;
    end else begin
      sc_r <= sample_clk;
      if (sc_r && !sample_clk) sf_r <= 4'h0;
      else if (sf_r != 4'hf) sf_r <= sf_r + 4'h1;
      if (sc_r && !sample_clk && nf_r != 2'h3) nf_r <= nf_r + 2'h1;
    end
  end
  property p_fall_only; $changed(w) |-> sf_r < 4'h7; endproperty
  a_fall_only: assert property (p_fall_only)
    else $error("word moved off a fall");
  property p_no_comb; $fell(sample_clk) |-> $stable(w); endproperty
  a_no_comb: assert property (p_no_comb)
    else $error("word moved with the pin");
  property p_whole; $changed(w) |=> $stable(w) [*4]; endproperty
  a_whole: assert property (p_whole)
    else $error("word split");
  property p_clamp; over_range |-> w[9:0] == {10{result_bit_top}}; endproperty
  a_clamp: assert property (p_clamp)
    else $error("over-range code not clamped");
  property p_depth; $changed(w) |-> nf_r == 2'h3; endproperty
  a_depth: assert property (p_depth)
    else $error("result too early");
  property p_rst; $rose(resetn) |-> (w == 11'h000) [*8]; endproperty
  a_rst: assert property (p_rst)
    else $error("word not clear after reset");
endmodule // tba_monitor
bind tba_top tba_monitor u_mon (.clk_sys, .resetn, .sample_clk, .over_range,
  .result_bit_top, .result_bits_upper_mid, .result_bits_lower_mid, .result_bit_bottom);
`default_nettype wire

// >>> dv/testbench.sv
// bench: random and corner samples through the pipeline
// assumes design, checker and capture model compiled first
`timescale 1ns/10ps
`default_nettype none
`include "tba_cfg.svh"
module testbench;
  import tba_pkg::*;
  logic clk_sys = 1'h0, resetn = 1'h0, run = 1'h0, sample_clk, stb;
  logic [3:0] hi = 4'h5, lo = 4'h5, result_bits_upper_mid, result_bits_lower_mid;
  logic result_bit_top, result_bit_bottom, over_range, rate_fault, duty_fault;
  logic signed [`TBA_IN_W-1:0] lvl = '0, q[$];
  logic signed [`TBA_IN_W-1:0] cn[10] = '{12'hdfe, 12'hdff, 12'he00, 12'hfff,
    12'h000, 12'h1ff, 12'h200, 12'h201, 12'h7ff, 12'h800};
  logic [31:0] r;
  tba_word_s cap;
  logic chk_flt = 1'h1;
  int n_mismatch = 0, cmp_count = 0, seed = 20, s = 0;
  tba_top i_tba_top (.clk_sys, .resetn, .sample_clk, .analog_level(lvl),
    .result_bit_top, .result_bits_upper_mid, .result_bits_lower_mid,
    .result_bit_bottom, .over_range, .rate_fault, .duty_fault);
  tba_cap i_tba_cap (.clk_sys, .run, .hi, .lo, .sample_clk, .stb, .cap,
    .pins({over_range, result_bit_top, result_bits_upper_mid,
           result_bits_lower_mid, result_bit_bottom}));
  // expected word: clamp, offset, over-range flag
  function automatic tba_word_s ex(input logic signed [`TBA_IN_W-1:0] v);
    tba_word_s w;
    w.over_range = v < -513 || v > 512;
    w.code = v < -512 ? 10'h000 : v > 511 ? 10'h3ff : 10'(v + 512);
    return w;
  endfunction
  task automatic cmp(input logic [10:0] g, input logic [10:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: flag got %b want %b", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #20000;
    n_mismatch++;
    conclude;
  end
  // each latched word against the sample of two periods back
  always @(posedge clk_sys) if (stb === 1'b1) begin
    if (s < 2) cmp(cap, 11'h000);
    else begin
      cmp(cap, ex(q.pop_front()));
      if (chk_flt) cmp_flag(rate_fault | duty_fault, 1'b0);
    end
    s++;
  end
  // reset, sample stream, then a stopped clock
  initial begin
    repeat (6) @(negedge clk_sys);
    resetn = 1'h1;
    repeat (4) @(negedge clk_sys);
    q.push_back(lvl);
    run = 1'h1;
    repeat (60) begin
      @(negedge sample_clk);
      repeat (2) @(negedge clk_sys);
      r = $random(seed);
      lvl = r[3] ? cn[r[7:4] % 10] : r[27:16];
      hi = 4'h4 + 4'(r[9]);
      lo = 4'h4 + 4'(r[10]);
      q.push_back(lvl);
    end
    run = 1'h0;
    repeat (10) @(negedge clk_sys);
    $display("test stream done");
    repeat (20) @(negedge clk_sys);
    cmp_flag(rate_fault, 1'b1);
    $display("test stopped clock done");
    // skewed duty, period still legal; flags settle only at rises
    chk_flt = 1'h0;
    hi = 4'h7;
    lo = 4'h3;
    run = 1'h1;
    repeat (6) begin
      @(negedge sample_clk);
      q.push_back(lvl);
    end
    cmp_flag(duty_fault, 1'b1);
    cmp_flag(rate_fault, 1'b0);
    $display("test skewed duty done");
    conclude;
  end
endmodule // testbench
`default_nettype wire

// >>> logic/tba_cfg.svh
// named constants for the ten bit sampling converter output block
// assumes inclusion by bare name from the package and the design files
`ifndef TBA_CFG_SVH
`define TBA_CFG_SVH

// system clock period, in ns
`define TBA_CLK_PERIOD_NS     10
// least sample rate the far end must keep, in MSPS
`define TBA_MIN_RATE_MSPS     10
// longest legal sample period in system cycles, rounded down
`define TBA_MAX_PERIOD_CYC    ((1000 / `TBA_MIN_RATE_MSPS) / `TBA_CLK_PERIOD_NS)
// duty cycle window, in percent of the period
`define TBA_DUTY_LO_PCT       40
`define TBA_DUTY_HI_PCT       60
`define TBA_PCT_SCALE         100
// width of the period counters
`define TBA_CNT_W             8
// input sample width and output word width
`define TBA_IN_W              12
`define TBA_CODE_W            10
// full scale limits, in input units of one lsb
`define TBA_FS_NEG            12'hE00
`define TBA_FS_POS            12'h1FF
`define TBA_OR_NEG            12'hDFF
`define TBA_OR_POS            12'h200
// offset binary: code of the zero input point
`define TBA_CODE_OFFSET       12'h200
// output bit slices
`define TBA_BIT_TOP           9
`define TBA_UMID_HI           8
`define TBA_UMID_LO           5
`define TBA_LMID_HI           4
`define TBA_LMID_LO           1
`define TBA_BIT_BOTTOM        0

`endif

// >>> logic/tba_pkg.sv
// types shared by the converter output block
// assumes tba_cfg.svh is on the include path
`include "tba_cfg.svh"

package tba_pkg;

  // one conversion result with its over-range flag
  typedef struct packed {
    logic                     over_range;
    logic [`TBA_CODE_W-1:0]   code;
  } tba_word_s;

  typedef logic [`TBA_CNT_W-1:0] tba_cnt_t;

  // sampling clock monitor state
  typedef enum logic [1:0] {
    TBA_IDLE,
    TBA_HIGH,
    TBA_LOW
  } tba_mon_e;

endpackage

// >>> logic/tba_sync.sv
// three stage synchroniser with agreement filter and edge pulses
// assumes pin_in is asynchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none

module tba_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import tba_pkg::*;

  logic s1_r, s2_r, s3_r, level_r, rise_r, fall_r;
  logic level_nxt, rise_nxt, fall_nxt;

  // level follows only once the second and third stage agree
  always_comb begin
    level_nxt = level_r;
    if (s2_r == s3_r) begin
      level_nxt = s3_r;
    end
    rise_nxt = level_nxt & ~level_r;
    fall_nxt = ~level_nxt & level_r;
  end

  // stage registers, first one read only by the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
    end else begin
      s1_r    <= pin_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
      rise_r  <= rise_nxt;
      fall_r  <= fall_nxt;
    end
  end

  assign level = level_r;
  assign rise  = rise_r;
  assign fall  = fall_r;

endmodule // tba_sync

`default_nettype wire

// >>> logic/tba_top.sv
// output side of a ten bit sampling converter: sample on the rising
// edge of the sample clock, launch the word on a later falling edge
// assumes sample_clk is a pin from the capture logic and analog_level
// is an already quantised input value on clk_sys
`timescale 1ns/10ps
`default_nettype none

`include "tba_cfg.svh"

// Overview of operation
// - rising sample clock holds input, starts conversion
// - output word changes on falling edge only
// - ten bit result word, all bits together
// - top bit most weight, bottom bit least
// - over-range high beyond full scale by more than one lsb
// - result latency two and a half periods
module tba_top (
  input  wire logic                            clk_sys,
  input  wire logic                            resetn,
  input  wire logic                            sample_clk,
  input  wire logic signed [`TBA_IN_W-1:0]     analog_level,
  output logic                                 result_bit_top,
  output logic [3:0]                           result_bits_upper_mid,
  output logic [3:0]                           result_bits_lower_mid,
  output logic                                 result_bit_bottom,
  output logic                                 over_range,
  output logic                                 rate_fault,
  output logic                                 duty_fault
);
  import tba_pkg::*;

  // quantise one held sample into an offset binary code and flag
  // inputs past either limit clamp to the end codes, so a capture side
  // that reads only the word still sees a monotonic transfer
  function automatic tba_word_s convert(input logic signed [`TBA_IN_W-1:0] v);
    tba_word_s                   w;
    logic signed [`TBA_IN_W-1:0] c;
    w = '0;
    c = v;
    // flag only once the input is more than a full lsb past either limit
    w.over_range = (v < $signed(`TBA_OR_NEG)) || (v > $signed(`TBA_OR_POS));
    if (v < $signed(`TBA_FS_NEG)) begin
      c = $signed(`TBA_FS_NEG);
    end else if (v > $signed(`TBA_FS_POS)) begin
      c = $signed(`TBA_FS_POS);
    end
    // offset binary: the negative limit maps to code zero
    c = c + $signed(`TBA_CODE_OFFSET);
    w.code = c[`TBA_CODE_W-1:0];
    return w;
  endfunction

  // reset release through two flip-flops
  // assertion is immediate, release is delayed so that no stage leaves
  // reset on a different edge from its neighbours
  logic rst_s1_r, rst_n_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // sample clock arrives from a pin, so it is filtered first
  // the filter costs about four system cycles on each edge; both edges
  // are delayed alike, so phase lengths are kept
  logic smp_level, smp_rise, smp_fall;

  tba_sync u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_r),
    .pin_in  (sample_clk),
    .level   (smp_level),
    .rise    (smp_rise),
    .fall    (smp_fall)
  );

  // conversion pipeline
  // the input is taken one cycle after the rise is seen, so the source
  // must keep it steady for that long
  tba_word_s held_r, held_nxt;
  tba_word_s mid_r,  mid_nxt;
  tba_word_s fin_r,  fin_nxt;
  tba_word_s out_r,  out_nxt;

  // three stages advance on rising edges, the launch on falling ones
  always_comb begin
    held_nxt = held_r;
    mid_nxt  = mid_r;
    fin_nxt  = fin_r;
    out_nxt  = out_r;
    // a rise pulse and a fall pulse never share a cycle
    if (smp_rise) begin
      held_nxt = convert(analog_level);
      mid_nxt  = held_r;
      fin_nxt  = mid_r;
    end
    // sample taken at rise n reaches the pins on the fall after rise n+2
    if (smp_fall) begin
      out_nxt = fin_r;
    end
  end

  // pipeline registers
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      held_r <= '0;
      mid_r  <= '0;
      fin_r  <= '0;
      out_r  <= '0;
    end else begin
      held_r <= held_nxt;
      mid_r  <= mid_nxt;
      fin_r  <= fin_nxt;
      out_r  <= out_nxt;
    end
  end

  // sample clock monitor: the converter relies on a steady clock
  // a slow or stalled clock would let a real held value droop; here
  // the condition is only flagged, never acted on
  // longest legal period in system cycles, from the lowest rate
  localparam tba_cnt_t MAX_PER = `TBA_CNT_W'(`TBA_MAX_PERIOD_CYC);

  // rate and duty verdicts, kept until the next judgement; rate is also raised as soon as a phase runs past MAX_PER
  tba_mon_e mon_r,  mon_nxt;
  tba_cnt_t hi_r,   hi_nxt;
  tba_cnt_t lo_r,   lo_nxt;
  logic     rate_r, rate_nxt;
  logic     duty_r, duty_nxt;

  // check the high share of a period against the duty window
  // products are kept at twice the counter width so no term wraps
  function automatic logic duty_bad(input tba_cnt_t hi, input tba_cnt_t lo);
    logic [2*`TBA_CNT_W-1:0] per;
    logic [2*`TBA_CNT_W-1:0] hs;
    per = ({`TBA_CNT_W'(0), hi} + {`TBA_CNT_W'(0), lo});
    hs  = {`TBA_CNT_W'(0), hi} * (2*`TBA_CNT_W)'(`TBA_PCT_SCALE);
    return (hs < per * (2*`TBA_CNT_W)'(`TBA_DUTY_LO_PCT)) ||
           (hs > per * (2*`TBA_CNT_W)'(`TBA_DUTY_HI_PCT));
  endfunction

  // count high and low time, judge each full period at a rising edge
  always_comb begin
    mon_nxt  = mon_r;
    hi_nxt   = hi_r;
    lo_nxt   = lo_r;
    rate_nxt = rate_r;
    duty_nxt = duty_r;
    case (mon_r)
      TBA_IDLE: begin
        if (smp_rise) begin
          mon_nxt = TBA_HIGH;
          hi_nxt  = `TBA_CNT_W'(1);
          lo_nxt  = '0;
        end
      end
      TBA_HIGH: begin
        if (smp_fall) begin
          mon_nxt = TBA_LOW;
          lo_nxt  = `TBA_CNT_W'(1);
        end else if (hi_r > MAX_PER) begin
          rate_nxt = 1'b1;
        end else begin
          hi_nxt = hi_r + `TBA_CNT_W'(1);
        end
      end
      TBA_LOW: begin
        if (smp_rise) begin
          mon_nxt  = TBA_HIGH;
          rate_nxt = (hi_r + lo_r) > MAX_PER;
          duty_nxt = duty_bad(hi_r, lo_r);
          hi_nxt   = `TBA_CNT_W'(1);
          lo_nxt   = '0;
        end else if (lo_r > MAX_PER) begin
          rate_nxt = 1'b1;
        end else begin
          lo_nxt = lo_r + `TBA_CNT_W'(1);
        end
      end
      default: begin
        mon_nxt = TBA_IDLE;
      end
    endcase
  end

  // monitor registers
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mon_r  <= TBA_IDLE;
      hi_r   <= '0;
      lo_r   <= '0;
      rate_r <= 1'b0;
      duty_r <= 1'b0;
    end else begin
      mon_r  <= mon_nxt;
      hi_r   <= hi_nxt;
      lo_r   <= lo_nxt;
      rate_r <= rate_nxt;
      duty_r <= duty_nxt;
    end
  end

  // word and flag leave one register together, top bit most weight
  // so a capture can never see a code torn from its flag
  assign result_bit_top        = out_r.code[`TBA_BIT_TOP];
  assign result_bits_upper_mid = out_r.code[`TBA_UMID_HI:`TBA_UMID_LO];
  assign result_bits_lower_mid = out_r.code[`TBA_LMID_HI:`TBA_LMID_LO];
  assign result_bit_bottom     = out_r.code[`TBA_BIT_BOTTOM];
  assign over_range            = out_r.over_range;
  assign rate_fault            = rate_r;
  assign duty_fault            = duty_r;

endmodule // tba_top

`default_nettype wire
